/* spcg_pkg.sv */
package spcg_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] SLEEP_GATE_OFS = 12'h118;
    localparam logic [11:0] RUN_GATE_OFS = 12'h100;
    localparam logic [11:0] DEEP_GATE_OFS = 12'h128;
    localparam logic [11:0] RUN_CFG_OFS = 12'h060;
    localparam logic [11:0] MODE_STAT_OFS = 12'h140;
    localparam int NPORTS = 5;
    localparam int ACG_BIT = 27;
    localparam logic [4:0] GATE_RST = 5'h00;
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    localparam logic [31:0] ERR_VAL = 32'hDEAD_0BAD;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SPCG_RUN = 2'h0,
        SPCG_SLEEP = 2'h1,
        SPCG_DEEP = 2'h3
    } spcg_mode_t;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } spcg_apb_req_t;

    typedef struct packed {
        logic sel;
        logic write;
        logic [2:0] port;
    } spcg_port_req_t;
endpackage

/* spcg_top.sv */
`timescale 1ns/10ps
module spcg_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SLEEP_REQ,
    input wire logic DEEP_REQ,
    input wire logic PORT_SEL,
    input wire logic PORT_WRITE,
    input wire logic [2:0] PORT_IDX,
    output logic PORT_FAULT,
    output logic [4:0] PORT_CLK_EN
);
    // ------------------------------------------------------------
    // request carriers and mode sync
    // ------------------------------------------------------------
    spcg_pkg::spcg_apb_req_t apb;
    spcg_pkg::spcg_port_req_t prq;
    logic [1:0] slp_s1_r, slp_s1_nxt, slp_s2_r, slp_s2_nxt;
    spcg_pkg::spcg_mode_t mode_r, mode_nxt;

    assign apb = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};
    assign prq = '{sel: PORT_SEL, write: PORT_WRITE, port: PORT_IDX};

    always_comb begin
        slp_s1_nxt = {DEEP_REQ, SLEEP_REQ};
        slp_s2_nxt = slp_s1_r;
        if (slp_s2_r[1]) begin
            mode_nxt = spcg_pkg::SPCG_DEEP;
        end else if (slp_s2_r[0]) begin
            mode_nxt = spcg_pkg::SPCG_SLEEP;
        end else begin
            mode_nxt = spcg_pkg::SPCG_RUN;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            slp_s1_r <= 2'h0;
            slp_s2_r <= 2'h0;
            mode_r <= spcg_pkg::SPCG_RUN;
        end else begin
            slp_s1_r <= slp_s1_nxt;
            slp_s2_r <= slp_s2_nxt;
            mode_r <= mode_nxt;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [4:0] run_gate_r, run_gate_nxt;
    logic [4:0] sleep_gate_r, sleep_gate_nxt;
    logic [4:0] deep_gate_r, deep_gate_nxt;
    logic acg_r, acg_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic access, wr;

    function automatic logic known_addr(input logic [11:0] a);
        return a == spcg_pkg::SLEEP_GATE_OFS || a == spcg_pkg::RUN_GATE_OFS ||
            a == spcg_pkg::DEEP_GATE_OFS || a == spcg_pkg::RUN_CFG_OFS ||
            a == spcg_pkg::MODE_STAT_OFS;
    endfunction

    // one wait state: setup, access, then answer registered
    assign access = apb.sel && apb.enable && !pready_r;
    assign wr = access && apb.write;

    always_comb begin
        run_gate_nxt = run_gate_r;
        sleep_gate_nxt = sleep_gate_r;
        deep_gate_nxt = deep_gate_r;
        acg_nxt = acg_r;
        prdata_nxt = prdata_r;
        pready_nxt = access;
        pslverr_nxt = access && !known_addr(apb.addr);
        if (wr) begin
            // upper bits dropped on write
            case (apb.addr)
                spcg_pkg::SLEEP_GATE_OFS: sleep_gate_nxt = apb.wdata[4:0];
                spcg_pkg::RUN_GATE_OFS: run_gate_nxt = apb.wdata[4:0];
                spcg_pkg::DEEP_GATE_OFS: deep_gate_nxt = apb.wdata[4:0];
                spcg_pkg::RUN_CFG_OFS: acg_nxt = apb.wdata[spcg_pkg::ACG_BIT];
                default: ;
            endcase
        end
        if (access && !apb.write) begin
            case (apb.addr)
                spcg_pkg::SLEEP_GATE_OFS: prdata_nxt = {27'h0, sleep_gate_r};
                spcg_pkg::RUN_GATE_OFS: prdata_nxt = {27'h0, run_gate_r};
                spcg_pkg::DEEP_GATE_OFS: prdata_nxt = {27'h0, deep_gate_r};
                spcg_pkg::RUN_CFG_OFS: prdata_nxt = 32'(acg_r) << spcg_pkg::ACG_BIT;
                spcg_pkg::MODE_STAT_OFS: prdata_nxt = {25'h0, mode_r, PORT_CLK_EN};
                default: prdata_nxt = spcg_pkg::REG_RST;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            run_gate_r <= spcg_pkg::GATE_RST;
            sleep_gate_r <= spcg_pkg::GATE_RST;
            deep_gate_r <= spcg_pkg::GATE_RST;
            acg_r <= 1'b0;
            prdata_r <= spcg_pkg::REG_RST;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            run_gate_r <= run_gate_nxt;
            sleep_gate_r <= sleep_gate_nxt;
            deep_gate_r <= deep_gate_nxt;
            acg_r <= acg_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;

    // ------------------------------------------------------------
    // effective enables and fault
    // ------------------------------------------------------------
    logic [4:0] clk_en_r, clk_en_nxt;
    logic fault_r, fault_nxt;

    always_comb begin
        // run gates unless auto gating is on in sleep or deep mode
        clk_en_nxt = run_gate_r;
        if (acg_r) begin
            case (mode_r)
                spcg_pkg::SPCG_SLEEP: clk_en_nxt = sleep_gate_r;
                spcg_pkg::SPCG_DEEP: clk_en_nxt = deep_gate_r;
                default: clk_en_nxt = run_gate_r;
            endcase
        end
        // unknown port index treated as gated
        fault_nxt = prq.sel && (prq.port >= 3'(spcg_pkg::NPORTS) ||
            !clk_en_r[prq.port]);
    end

    // registered enable feeds an external latch-based gate, so no glitch
    always_ff @(posedge CLK) begin
        if (RST) begin
            clk_en_r <= spcg_pkg::GATE_RST;
            fault_r <= 1'b0;
        end else begin
            clk_en_r <= clk_en_nxt;
            fault_r <= fault_nxt;
        end
    end

    assign PORT_CLK_EN = clk_en_r;
    assign PORT_FAULT = fault_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_sleep_write;
        wr && apb.addr == spcg_pkg::SLEEP_GATE_OFS;
    endsequence

    AST_RESET_CLEAR: assert property (@(posedge CLK) $past(RST) |-> sleep_gate_r == 5'h00)
        else $error("sleep gate not clear after reset");
    AST_WRITE_STORES: assert property (@(posedge CLK) disable iff (RST)
        s_sleep_write |=> sleep_gate_r == $past(apb.wdata[4:0]))
        else $error("sleep gate write lost");
    AST_RSVD_ZERO: assert property (@(posedge CLK) disable iff (RST)
        access && !apb.write && apb.addr == spcg_pkg::SLEEP_GATE_OFS |=> PRDATA[31:5] == 27'h0)
        else $error("reserved bits nonzero");
    AST_SLEEP_SEL: assert property (@(posedge CLK) disable iff (RST)
        acg_r && mode_r == spcg_pkg::SPCG_SLEEP |=> PORT_CLK_EN == $past(sleep_gate_r))
        else $error("sleep enables not applied");
    AST_NO_ACG: assert property (@(posedge CLK) disable iff (RST)
        !acg_r |=> PORT_CLK_EN == $past(run_gate_r))
        else $error("run enables not applied");
    AST_FAULT: assert property (@(posedge CLK) disable iff (RST)
        prq.sel && prq.port < 3'h5 && !clk_en_r[prq.port] |=> PORT_FAULT)
        else $error("gated access not faulted");
    AST_NO_FAULT: assert property (@(posedge CLK) disable iff (RST)
        prq.sel && prq.port < 3'h5 && clk_en_r[prq.port] |=> !PORT_FAULT)
        else $error("spurious fault");
    AST_READY: assert property (@(posedge CLK) disable iff (RST)
        apb.sel && apb.enable && !pready_r |=> PREADY ##1 !PREADY)
        else $error("apb answer timing");
    AST_GATED_OFF: assert property (@(posedge CLK) disable iff (RST)
        acg_r && mode_r == spcg_pkg::SPCG_SLEEP && $stable(sleep_gate_r) && !sleep_gate_r[0]
        |=> !PORT_CLK_EN[0])
        else $error("port a not gated");
    AST_ONE_CHANGE: assert property (@(posedge CLK) disable iff (RST)
        $changed(PORT_CLK_EN) |-> $past(clk_en_nxt) == PORT_CLK_EN)
        else $error("enable changed off edge");

    // ------------------------------------------------------------
    // mode tracking and bus answers
    // ------------------------------------------------------------
    sequence s_read_access;
        access && !apb.write;
    endsequence

    sequence s_unmapped_access;
        access && !known_addr(apb.addr);
    endsequence

    sequence s_sleep_active;
        acg_r && mode_r == spcg_pkg::SPCG_SLEEP;
    endsequence

    // mode follows the second sync stage one edge later
    AST_MODE_DEEP: assert property (@(posedge CLK) disable iff (RST)
        slp_s2_r[1] |=> mode_r == spcg_pkg::SPCG_DEEP)
        else $error("deep mode not entered");
    AST_MODE_SLEEP: assert property (@(posedge CLK) disable iff (RST)
        slp_s2_r == 2'h1 |=> mode_r == spcg_pkg::SPCG_SLEEP)
        else $error("sleep mode not entered");
    AST_MODE_RUN: assert property (@(posedge CLK) disable iff (RST)
        slp_s2_r == 2'h0 |=> mode_r == spcg_pkg::SPCG_RUN)
        else $error("run mode not entered");
    AST_SYNC_TWO: assert property (@(posedge CLK) disable iff (RST)
        1'b1 |=> slp_s2_r == $past(slp_s1_r))
        else $error("sync stage skipped");

    // enables lag the selecting state by one edge, hence past values
    AST_DEEP_SEL: assert property (@(posedge CLK) disable iff (RST)
        acg_r && mode_r == spcg_pkg::SPCG_DEEP |=> PORT_CLK_EN == $past(deep_gate_r))
        else $error("deep enables not applied");
    AST_RUN_SEL: assert property (@(posedge CLK) disable iff (RST)
        acg_r && mode_r == spcg_pkg::SPCG_RUN |=> PORT_CLK_EN == $past(run_gate_r))
        else $error("run enables not applied in run");
    AST_SLEEP_GATED: assert property (@(posedge CLK) disable iff (RST)
        s_sleep_active |=> (PORT_CLK_EN & ~$past(sleep_gate_r)) == 5'h00)
        else $error("cleared port still clocked");
    AST_CFG_STORE: assert property (@(posedge CLK) disable iff (RST)
        wr && apb.addr == spcg_pkg::RUN_CFG_OFS |=> acg_r == $past(apb.wdata[spcg_pkg::ACG_BIT]))
        else $error("auto gating bit lost");
    AST_WRITE_RUN: assert property (@(posedge CLK) disable iff (RST)
        wr && apb.addr == spcg_pkg::RUN_GATE_OFS |=> run_gate_r == $past(apb.wdata[4:0]))
        else $error("run gate write lost");
    AST_WRITE_DEEP: assert property (@(posedge CLK) disable iff (RST)
        wr && apb.addr == spcg_pkg::DEEP_GATE_OFS |=> deep_gate_r == $past(apb.wdata[4:0]))
        else $error("deep gate write lost");
    AST_NO_ACCESS_KEEP: assert property (@(posedge CLK) disable iff (RST)
        !wr |=> $stable(sleep_gate_r))
        else $error("sleep gate changed without write");

    // register bus answers
    AST_READ_SLEEP: assert property (@(posedge CLK) disable iff (RST)
        s_read_access ##0 apb.addr == spcg_pkg::SLEEP_GATE_OFS |=> PRDATA == {27'h0, $past(sleep_gate_r)})
        else $error("sleep gate read wrong");
    AST_UNMAPPED_ERR: assert property (@(posedge CLK) disable iff (RST)
        s_unmapped_access |=> PSLVERR && PREADY)
        else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (@(posedge CLK) disable iff (RST)
        access && known_addr(apb.addr) |=> !PSLVERR)
        else $error("mapped access refused");
    AST_UNMAPPED_ZERO: assert property (@(posedge CLK) disable iff (RST)
        s_unmapped_access ##0 !apb.write |=> PRDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_UNMAPPED_KEEP: assert property (@(posedge CLK) disable iff (RST)
        s_unmapped_access |=> $stable(sleep_gate_r))
        else $error("unmapped write landed");
    AST_PRDATA_HOLD: assert property (@(posedge CLK) disable iff (RST)
        !(access && !apb.write) |=> $stable(PRDATA))
        else $error("read data moved without read");
    AST_READY_IDLE: assert property (@(posedge CLK) disable iff (RST)
        !apb.sel |=> !PREADY)
        else $error("answer without request");

    // port side faults
    AST_IDX_FAULT: assert property (@(posedge CLK) disable iff (RST)
        prq.sel && prq.port >= 3'h5 |=> PORT_FAULT)
        else $error("missing port not faulted");
    AST_IDLE_NO_FAULT: assert property (@(posedge CLK) disable iff (RST)
        !prq.sel |=> !PORT_FAULT)
        else $error("fault without access");

    // reset covers the mid-run case too, so no disable here
    AST_RESET_OUTS: assert property (@(posedge CLK)
        RST |=> !PREADY && !PSLVERR && !PORT_FAULT && PORT_CLK_EN == 5'h00)
        else $error("outputs not clear after reset");
endmodule

/* spcg_top_tb.sv */
`timescale 1ns/10ps
module spcg_top_tb;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, PREADY, PSLVERR, PORT_FAULT;
    logic SLEEP_REQ = 1'b0, DEEP_REQ = 1'b0, PORT_SEL = 1'b0, PORT_WRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic [2:0] PORT_IDX = 3'h0;
    logic [4:0] PORT_CLK_EN, run_v, slp_v, dep_v;
    logic [33:0] apb_q[$];
    logic port_q[$];
    logic pend = 1'b0;
    int err_total = 0, tests_run = 0, seed = 85;

    spcg_top uut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP_REQ(SLEEP_REQ),
        .DEEP_REQ(DEEP_REQ), .PORT_SEL(PORT_SEL), .PORT_WRITE(PORT_WRITE), .PORT_IDX(PORT_IDX),
        .PORT_FAULT(PORT_FAULT), .PORT_CLK_EN(PORT_CLK_EN));

    always #25 CLK = ~CLK;

    task give_verdict;
        $display("compares %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task cmp_flag(input logic got, input logic exp);
        cmp({31'h0, got}, {31'h0, exp});
    endtask

    task cmp_en(input logic [4:0] got, input logic [4:0] exp);
        cmp({27'h0, got}, {27'h0, exp});
    endtask

    // ------------------------------------------------------------
    // apb master: request held until pready sampled high
    // ------------------------------------------------------------
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic sl, input logic [31:0] rd);
        int n;
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        apb_q.push_back({w, sl, rd});
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n >= 20) begin
            err_total++;
            give_verdict();
        end
    endtask

    // ------------------------------------------------------------
    // watcher: oldest note against each result
    // ------------------------------------------------------------
    always @(posedge CLK) begin
        logic [33:0] e;
        if (PSEL && PENABLE && PREADY === 1'b1 && apb_q.size() > 0) begin
            e = apb_q.pop_front();
            cmp_flag(PSLVERR, e[32]);
            if (!e[33]) cmp(PRDATA, e[31:0]);
        end
        if (pend && port_q.size() > 0) cmp_flag(PORT_FAULT, port_q.pop_front());
        pend = PORT_SEL;
    end

    // back-to-back port hits, index 5 is past the last port
    task mode_chk(input logic [4:0] eff);
        repeat (6) @(posedge CLK);
        cmp_en(PORT_CLK_EN, eff);
        for (int i = 0; i < 6; i++) begin
            @(posedge CLK);
            PORT_SEL <= 1'b1;
            PORT_IDX <= i[2:0];
            PORT_WRITE <= seed[0];
            port_q.push_back((i > 4) ? 1'b1 : !eff[i]);
        end
        @(posedge CLK);
        PORT_SEL <= 1'b0;
        repeat (2) @(posedge CLK);
        $display("mode test done en=%h", eff);
    endtask

    initial begin
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        cmp_en(PORT_CLK_EN, 5'h00);
        apb(1'b0, spcg_pkg::SLEEP_GATE_OFS, 32'h0, 1'b0, 32'h0);
        {run_v, slp_v, dep_v} = 15'($random(seed));
        apb(1'b1, spcg_pkg::RUN_GATE_OFS, {27'h0, run_v}, 1'b0, 32'h0);
        apb(1'b1, spcg_pkg::SLEEP_GATE_OFS, {27'($random(seed)), slp_v}, 1'b0, 32'h0);
        apb(1'b0, spcg_pkg::SLEEP_GATE_OFS, 32'h0, 1'b0, {27'h0, slp_v});
        apb(1'b1, spcg_pkg::SLEEP_GATE_OFS, {27'h0, slp_v}, 1'b0, 32'h0);
        apb(1'b0, spcg_pkg::SLEEP_GATE_OFS, 32'h0, 1'b0, {27'h0, slp_v});
        apb(1'b1, spcg_pkg::DEEP_GATE_OFS, {27'h0, dep_v}, 1'b0, 32'h0);
        apb(1'b1, 12'h004, 32'hFFFF_FFFF, 1'b1, 32'h0);
        apb(1'b0, 12'h004, 32'h0, 1'b1, 32'h0);
        mode_chk(run_v);
        SLEEP_REQ <= 1'b1;
        mode_chk(run_v);
        apb(1'b1, spcg_pkg::RUN_CFG_OFS, 32'h1 << spcg_pkg::ACG_BIT, 1'b0, 32'h0);
        mode_chk(slp_v);
        DEEP_REQ <= 1'b1;
        mode_chk(dep_v);
        DEEP_REQ <= 1'b0;
        apb(1'b1, spcg_pkg::SLEEP_GATE_OFS, 32'hFFFF_FFFF, 1'b0, 32'h0);
        mode_chk(5'h1F);
        apb(1'b1, spcg_pkg::SLEEP_GATE_OFS, 32'h0, 1'b0, 32'h0);
        mode_chk(5'h00);
        SLEEP_REQ <= 1'b0;
        mode_chk(run_v);
        // second reset in mid-run must clear everything again
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        cmp_en(PORT_CLK_EN, 5'h00);
        apb(1'b0, spcg_pkg::SLEEP_GATE_OFS, 32'h0, 1'b0, 32'h0);
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge CLK);
        err_total++;
        give_verdict();
    end
endmodule
